// File: hw/fsrb_top.sv
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - busy set during program, erase, register write
// - latch low refuses writes, program and erase
// - protection fields change only by register write
// - protected region rejects program and erase
// - hardware protected mode blocks protection writes
// - granularity picks 64KB blocks or 4KB sectors
// - direction picks top-down or bottom-up growth
// - range zero means no block protection
// - two protect bits select register protection mode
// - high bit splits pin modes from lock-downs
// - low bit enables pin lock, ignored when high bit set
// - quad enable turns control pins into data
// - four-wire entry refused unless quad enabled
// - four-wire mode keeps quad enable set
// - security lock bits set once, never clear
// - suspend sets paused flag, resume clears it
// - invert swaps protected and writable regions
// - scheme select chooses range or block locks
// - pin select zero pause, one reset
// - drive field resets to binary 10
// - drive codes give 100/75/50/25 percent
// - pause or reset acts only without quad
module fsrb_top
    import fsrb_pkg::*;
#(
    parameter int PROG_CYC = FSRB_PROG_CYC,
    parameter int ERASE_CYC = FSRB_ERASE_CYC
)
(
    // system clock, reset, enable
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CE_I,
    // link from the host controller
    input wire logic LCLK_I,
    input wire logic REQ_VALID_I,
    input wire fsrb_req_s REQ_I,
    // pins
    input wire logic WP_N_I,
    input wire logic BLOCK_LOCK_HIT_I,
    // register readback
    output logic [7:0] SR_FLAGS_O,
    output logic [7:0] SR_QUAD_O,
    output logic [7:0] SR_CONFIG_O,
    // status toward the link and pads
    output logic REFUSED_O,
    output logic FOUR_WIRE_O,
    output fsrb_pad_s PAD_O
);

    typedef struct packed {
        fsrb_state_e state;
        logic [31:0] cnt;
        logic tog_seen;
        logic [7:0] sr1;
        logic [7:0] sr2;
        logic [7:0] sr3;
        logic [7:0] sr1_pend;
        logic [7:0] sr2_pend;
        logic [7:0] sr3_pend;
        logic pend_wr;
        logic four_wire;
        logic refused;
        fsrb_pad_s pad;
    } fsrb_top_s;

    fsrb_top_s st_ff;
    fsrb_top_s nxt_st;
    fsrb_req_s link_word;
    fsrb_req_s word_sync;
    logic link_tog;
    logic tog_sync;
    logic wp_n;

    // ------------------------------------------------------------
    // link domain capture and crossings
    // ------------------------------------------------------------
    fsrb_link u_link (
        .lclk_i(LCLK_I),
        .reset_n_i(RESET_N_I),
        .req_valid_i(REQ_VALID_I),
        .req_i(REQ_I),
        .word_o(link_word),
        .toggle_o(link_tog)
    );

    // toggle and write-protect pin cross on two flops
    fsrb_sync #(.WIDTH(2)) u_sync (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .ce_i(CE_I),
        .d_i({link_tog, WP_N_I}),
        .q_o({tog_sync, wp_n})
    );

    // word is stable once the synchronised toggle has moved
    assign word_sync = link_word;

    // ------------------------------------------------------------
    // protection decode
    // ------------------------------------------------------------
    logic [2:0] bp;
    logic [23:0] span;
    logic in_range;
    logic hit;
    logic hw_prot;
    logic sr_locked;

    always_comb
    begin
        bp = st_ff.sr1[FSRB_BP_HI:FSRB_BP_LO];
        // 111 with blocks covers the whole array, otherwise 2^(bp+1) blocks or 2^(bp-1) sectors
        if (st_ff.sr1[FSRB_BIT_SEC])
            span = 24'(((32'h1 << (bp - 3'h1)) << FSRB_SEC_SHIFT) - 1);
        else
            span = 24'(((32'h4 << (bp - 3'h1)) << FSRB_BLK_SHIFT) - 1);
        if (bp == FSRB_BP_NONE)
            in_range = 1'b0;
        else if (bp == 3'h7 && !st_ff.sr1[FSRB_BIT_SEC])
            in_range = 1'b1;
        else if (st_ff.sr1[FSRB_BIT_TB])
            in_range = word_sync.addr <= span;
        else
            in_range = word_sync.addr >= (FSRB_ARRAY_TOP - span);
        if (st_ff.sr3[FSRB_BIT_SCHEME])
            hit = BLOCK_LOCK_HIT_I;
        else
            hit = in_range ^ st_ff.sr2[FSRB_BIT_INV];
        // pin only protects while it is a control pin
        hw_prot = !st_ff.sr2[FSRB_BIT_SRPHI] && st_ff.sr1[FSRB_BIT_SRPLO]
            && !st_ff.sr2[FSRB_BIT_QE] && !wp_n;
        sr_locked = hw_prot || st_ff.sr2[FSRB_BIT_SRPHI];
    end

    // ------------------------------------------------------------
    // command execution and busy timing
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        if (CE_I)
        begin
            nxt_st.tog_seen = tog_sync;
            if (st_ff.state == FSRB_ST_BUSY)
            begin
                if (st_ff.cnt <= 32'h1)
                begin
                    nxt_st.state = FSRB_ST_IDLE;
                    nxt_st.sr1[FSRB_BIT_BUSY] = 1'b0;
                    if (st_ff.pend_wr)
                    begin
                        nxt_st.sr1 = st_ff.sr1_pend;
                        nxt_st.sr2 = st_ff.sr2_pend;
                        nxt_st.sr3 = st_ff.sr3_pend;
                    end
                    nxt_st.pend_wr = 1'b0;
                end
                else
                    nxt_st.cnt = st_ff.cnt - 32'h1;
            end
            if (tog_sync != st_ff.tog_seen)
            begin
                nxt_st.refused = 1'b0;
                case (word_sync.cmd)
                    FSRB_CMD_WREN:
                        if (st_ff.state == FSRB_ST_IDLE)
                            nxt_st.sr1[FSRB_BIT_WEL] = 1'b1;
                    FSRB_CMD_WRDI:
                        if (st_ff.state == FSRB_ST_IDLE)
                            nxt_st.sr1[FSRB_BIT_WEL] = 1'b0;
                    FSRB_CMD_WRSR:
                    begin
                        if (!st_ff.sr1[FSRB_BIT_WEL] || st_ff.state != FSRB_ST_IDLE
                            || sr_locked)
                            nxt_st.refused = 1'b1;
                        else
                        begin
                            nxt_st.sr1_pend = st_ff.sr1;
                            nxt_st.sr2_pend = st_ff.sr2;
                            nxt_st.sr3_pend = st_ff.sr3;
                            case (word_sync.idx)
                                FSRB_IDX_FLAGS:
                                    nxt_st.sr1_pend[7:2] = word_sync.data[7:2];
                                FSRB_IDX_QUAD:
                                begin
                                    nxt_st.sr2_pend[FSRB_BIT_INV] = word_sync.data[FSRB_BIT_INV];
                                    nxt_st.sr2_pend[FSRB_BIT_SRPHI] = word_sync.data[FSRB_BIT_SRPHI];
                                    nxt_st.sr2_pend[FSRB_BIT_QE] = word_sync.data[FSRB_BIT_QE]
                                        | st_ff.four_wire;
                                    // lock bits only ever set
                                    nxt_st.sr2_pend[FSRB_LB_HI:FSRB_LB_LO] =
                                        st_ff.sr2[FSRB_LB_HI:FSRB_LB_LO]
                                        | word_sync.data[FSRB_LB_HI:FSRB_LB_LO];
                                end
                                FSRB_IDX_CONFIG:
                                    nxt_st.sr3_pend = word_sync.data & FSRB_CFG_WMASK;
                                default:
                                    nxt_st.refused = 1'b1;
                            endcase
                            nxt_st.pend_wr = 1'b1;
                            nxt_st.sr1_pend[1:0] = 2'b00;
                            nxt_st.sr1[FSRB_BIT_WEL] = 1'b0;
                            nxt_st.sr1[FSRB_BIT_BUSY] = 1'b1;
                            nxt_st.state = FSRB_ST_BUSY;
                            nxt_st.cnt = 32'(FSRB_WRSR_CYC);
                        end
                    end
                    FSRB_CMD_PROG, FSRB_CMD_SERASE, FSRB_CMD_BERASE:
                    begin
                        if (!st_ff.sr1[FSRB_BIT_WEL] || st_ff.state != FSRB_ST_IDLE
                            || hit)
                            nxt_st.refused = 1'b1;
                        else
                        begin
                            nxt_st.sr1[FSRB_BIT_WEL] = 1'b0;
                            nxt_st.sr1[FSRB_BIT_BUSY] = 1'b1;
                            nxt_st.state = FSRB_ST_BUSY;
                            nxt_st.cnt = (word_sync.cmd == FSRB_CMD_PROG) ?
                                32'(PROG_CYC) : 32'(ERASE_CYC);
                        end
                    end
                    FSRB_CMD_SUSP:
                        if (st_ff.state == FSRB_ST_BUSY && !st_ff.pend_wr)
                        begin
                            nxt_st.state = FSRB_ST_PAUSE;
                            nxt_st.sr1[FSRB_BIT_BUSY] = 1'b0;
                            nxt_st.sr2[FSRB_BIT_PAUSED] = 1'b1;
                        end
                    FSRB_CMD_RESUME:
                        if (st_ff.state == FSRB_ST_PAUSE)
                        begin
                            nxt_st.state = FSRB_ST_BUSY;
                            nxt_st.sr1[FSRB_BIT_BUSY] = 1'b1;
                            nxt_st.sr2[FSRB_BIT_PAUSED] = 1'b0;
                        end
                    FSRB_CMD_QPI_IN:
                        if (st_ff.sr2[FSRB_BIT_QE])
                            nxt_st.four_wire = 1'b1;
                        else
                            nxt_st.refused = 1'b1;
                    FSRB_CMD_QPI_OUT:
                        nxt_st.four_wire = 1'b0;
                    default:
                        nxt_st.refused = 1'b0;
                endcase
            end
            // pad configuration follows the registers
            nxt_st.pad.quad_io_enable = nxt_st.sr2[FSRB_BIT_QE];
            nxt_st.pad.wp_active = !nxt_st.sr2[FSRB_BIT_QE];
            nxt_st.pad.pause_active = !nxt_st.sr2[FSRB_BIT_QE]
                && !nxt_st.sr3[FSRB_BIT_PINSEL];
            nxt_st.pad.reset_active = !nxt_st.sr2[FSRB_BIT_QE]
                && nxt_st.sr3[FSRB_BIT_PINSEL];
            nxt_st.pad.drive_strength_field = nxt_st.sr3[FSRB_DRV_HI:FSRB_DRV_LO];
            case (nxt_st.sr3[FSRB_DRV_HI:FSRB_DRV_LO])
                2'h0: nxt_st.pad.drive_pct = 7'h64;
                2'h1: nxt_st.pad.drive_pct = 7'h4b;
                2'h2: nxt_st.pad.drive_pct = 7'h32;
                default: nxt_st.pad.drive_pct = 7'h19;
            endcase
        end
    end

    // state register
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            st_ff <= '0;
            st_ff.sr1 <= FSRB_RST_FLAGS;
            st_ff.sr2 <= FSRB_RST_QUAD;
            st_ff.sr3 <= FSRB_RST_CONFIG;
            st_ff.pad.wp_active <= 1'b1;
            st_ff.pad.pause_active <= 1'b1;
            st_ff.pad.drive_strength_field <= 2'h2;
            st_ff.pad.drive_pct <= 7'h32;
        end
        else
            st_ff <= nxt_st;
    end

    // ------------------------------------------------------------
    // outputs, each straight from the state register
    // ------------------------------------------------------------
    assign SR_FLAGS_O = st_ff.sr1;
    assign SR_QUAD_O = st_ff.sr2;
    assign SR_CONFIG_O = st_ff.sr3;
    assign REFUSED_O = st_ff.refused;
    assign FOUR_WIRE_O = st_ff.four_wire;
    assign PAD_O = st_ff.pad;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    busy_tracks_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        st_ff.sr1[FSRB_BIT_BUSY] == (st_ff.state == FSRB_ST_BUSY))
        else $error("busy flag disagrees with state");
    wel_gate_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        (CE_I && !st_ff.sr1[FSRB_BIT_WEL] && st_ff.state == FSRB_ST_IDLE) |=>
        st_ff.state != FSRB_ST_BUSY)
        else $error("operation started without write enable");
    fields_stable_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        !st_ff.pend_wr |=> $stable(st_ff.sr1[7:2]))
        else $error("protection fields changed without register write");
    lock_sticky_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        ($past(st_ff.sr2[FSRB_LB_HI:FSRB_LB_LO]) & ~st_ff.sr2[FSRB_LB_HI:FSRB_LB_LO]) == 4'h0)
        else $error("security lock bit cleared");
    quad_held_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        st_ff.four_wire |-> st_ff.sr2[FSRB_BIT_QE])
        else $error("quad enable low in four-wire mode");
    qpi_entry_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        $rose(st_ff.four_wire) |-> $past(st_ff.sr2[FSRB_BIT_QE]))
        else $error("four-wire mode entered without quad enable");
    paused_flag_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        st_ff.sr2[FSRB_BIT_PAUSED] == (st_ff.state == FSRB_ST_PAUSE))
        else $error("paused flag disagrees with state");
    pin_func_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        st_ff.pad.quad_io_enable |-> !st_ff.pad.pause_active && !st_ff.pad.reset_active)
        else $error("pause or reset active with quad enabled");

endmodule

`default_nettype wire

// File: hw/fsrb_pkg.sv
package fsrb_pkg;

    // -------------------------------------------------------------
    // register indices (host command port addresses)
    // -------------------------------------------------------------
    localparam logic [1:0] FSRB_IDX_FLAGS = 2'h0;
    localparam logic [1:0] FSRB_IDX_QUAD = 2'h1;
    localparam logic [1:0] FSRB_IDX_CONFIG = 2'h2;

    // -------------------------------------------------------------
    // field positions, first register
    // -------------------------------------------------------------
    localparam int FSRB_BIT_BUSY = 0;
    localparam int FSRB_BIT_WEL = 1;
    localparam int FSRB_BP_LO = 2;
    localparam int FSRB_BP_HI = 4;
    localparam int FSRB_BIT_TB = 5;
    localparam int FSRB_BIT_SEC = 6;
    localparam int FSRB_BIT_SRPLO = 7;

    // -------------------------------------------------------------
    // field positions, second and third registers
    // -------------------------------------------------------------
    localparam int FSRB_BIT_SRPHI = 0;
    localparam int FSRB_BIT_QE = 1;
    localparam int FSRB_LB_LO = 2;
    localparam int FSRB_LB_HI = 5;
    localparam int FSRB_BIT_INV = 6;
    localparam int FSRB_BIT_PAUSED = 7;
    localparam int FSRB_BIT_SCHEME = 2;
    localparam int FSRB_DRV_LO = 5;
    localparam int FSRB_DRV_HI = 6;
    localparam int FSRB_BIT_PINSEL = 7;

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [7:0] FSRB_RST_FLAGS = 8'h00;
    localparam logic [7:0] FSRB_RST_QUAD = 8'h00;
    localparam logic [7:0] FSRB_RST_CONFIG = 8'h40;
    localparam logic [7:0] FSRB_CFG_WMASK = 8'he4;
    localparam logic [2:0] FSRB_BP_NONE = 3'h0;

    // -------------------------------------------------------------
    // array geometry: 256 blocks of 64KB, 4KB sectors
    // -------------------------------------------------------------
    localparam int FSRB_BLK_SHIFT = 16;
    localparam int FSRB_SEC_SHIFT = 12;
    localparam logic [23:0] FSRB_ARRAY_TOP = 24'hffffff;

    // -------------------------------------------------------------
    // operation timing in cycles of the system clock
    // -------------------------------------------------------------
    localparam int FSRB_CLK_MHZ = 10;
    localparam int FSRB_WRSR_US = 5;
    localparam int FSRB_WRSR_CYC = FSRB_WRSR_US * FSRB_CLK_MHZ;
    localparam int FSRB_PROG_US = 700;
    localparam int FSRB_PROG_CYC = FSRB_PROG_US * FSRB_CLK_MHZ;
    localparam int FSRB_ERASE_MS = 60;
    localparam int FSRB_ERASE_CYC = FSRB_ERASE_MS * 1000 * FSRB_CLK_MHZ;

    // -------------------------------------------------------------
    // link commands
    // -------------------------------------------------------------
    typedef enum logic [3:0] {
        FSRB_CMD_NONE = 4'h0,
        FSRB_CMD_WREN = 4'h1,
        FSRB_CMD_WRDI = 4'h2,
        FSRB_CMD_WRSR = 4'h3,
        FSRB_CMD_PROG = 4'h4,
        FSRB_CMD_SERASE = 4'h5,
        FSRB_CMD_BERASE = 4'h6,
        FSRB_CMD_SUSP = 4'h7,
        FSRB_CMD_RESUME = 4'h8,
        FSRB_CMD_QPI_IN = 4'h9,
        FSRB_CMD_QPI_OUT = 4'ha
    } fsrb_cmd_e;

    typedef enum logic [1:0] {
        FSRB_ST_IDLE = 2'b00,
        FSRB_ST_BUSY = 2'b01,
        FSRB_ST_PAUSE = 2'b10
    } fsrb_state_e;

    // command word carried from the link domain
    typedef struct packed {
        fsrb_cmd_e cmd;
        logic [1:0] idx;
        logic [7:0] data;
        logic [23:0] addr;
    } fsrb_req_s;

    // configuration outputs toward the pads
    typedef struct packed {
        logic quad_io_enable;
        logic wp_active;
        logic pause_active;
        logic reset_active;
        logic [1:0] drive_strength_field;
        logic [6:0] drive_pct;
    } fsrb_pad_s;

endpackage

// File: hw/fsrb_sync.sv
`timescale 1ns/100ps
`default_nettype none

// two-flop level synchroniser; the first flop feeds only the second
module fsrb_sync
    import fsrb_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } fsrb_sync_s;

    fsrb_sync_s st_ff;
    fsrb_sync_s nxt_st;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        if (ce_i)
        begin
            nxt_st.meta = d_i;
            nxt_st.sync = st_ff.meta;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign q_o = st_ff.sync;

endmodule

`default_nettype wire

// File: hw/fsrb_link.sv
`timescale 1ns/100ps
`default_nettype none

// link-side capture: a request is held and handed over by toggle
module fsrb_link
    import fsrb_pkg::*;
(
    // link clock and reset
    input wire logic lclk_i,
    input wire logic reset_n_i,
    // request from the host controller
    input wire logic req_valid_i,
    input wire fsrb_req_s req_i,
    // toward the system domain
    output fsrb_req_s word_o,
    output logic toggle_o
);

    typedef struct packed {
        fsrb_req_s word;
        logic toggle;
    } fsrb_link_s;

    fsrb_link_s st_ff;
    fsrb_link_s nxt_st;

    // ------------------------------------------------------------
    // hold the word and flip the toggle once per request
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        if (req_valid_i)
        begin
            nxt_st.word = req_i;
            nxt_st.toggle = ~st_ff.toggle;
        end
    end

    // state register
    always_ff @(posedge lclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign word_o = st_ff.word;
    assign toggle_o = st_ff.toggle;

endmodule

`default_nettype wire

// File: tb/fsrb_host.sv
`timescale 1ns/100ps
`default_nettype none

// host controller model: one request per call, word held after the pulse
module fsrb_host
    import fsrb_pkg::*;
(
    // link clock
    input wire logic lclk_i,
    // request toward the device
    output logic req_valid_o,
    output fsrb_req_s req_o
);
    // idle until the first request
    initial
    begin
        req_valid_o = 1'b0;
        req_o = '0;
    end

    // optional stall, then a one-cycle pulse on req_valid_o; the word
    // stays on req_o after the pulse until the next call
    task automatic issue(input fsrb_req_s w, input int stall);
        repeat (stall + 1) @(posedge lclk_i);
        req_o <= w;
        req_valid_o <= 1'b1;
        @(posedge lclk_i);
        req_valid_o <= 1'b0;
    endtask
endmodule

`default_nettype wire

// File: tb/test_flash_status_register_bank.sv
`timescale 1ns/100ps
`default_nettype none
`define C(n, e, g) begin n_compared++; if ((g) !== (e)) begin $display("mismatch %s expected %h seen %h", n, e, g); err_count++; end end

module test_flash_status_register_bank
    import fsrb_pkg::*;
;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst_n = 1'b0;
    logic wp_n = 1'b1;
    logic blk_hit = 1'b0;
    logic lv;
    fsrb_req_s lq;
    logic [7:0] s1, s2, s3;
    logic rf, fw;
    fsrb_pad_s pad;
    int err_count = 0;
    int n_compared = 0;
    integer seed = 32'h9df6ff3f;
    int m, k;
    // register model from the rules, checked after every register write made through wr
    int mdl[3] = '{0, 0, 8'h40};
    logic mfw = 1'b0;

    // system clock and an unrelated link clock
    initial forever #50 clk = ~clk;
    initial
    begin
        #13;
        forever #40 lclk = ~lclk;
    end

    // device and host model
    fsrb_top #(.PROG_CYC(20), .ERASE_CYC(60)) dut (.CLK_I(clk), .RESET_N_I(rst_n), .CE_I(1'b1),
        .LCLK_I(lclk), .REQ_VALID_I(lv), .REQ_I(lq), .WP_N_I(wp_n), .BLOCK_LOCK_HIT_I(blk_hit),
        .SR_FLAGS_O(s1), .SR_QUAD_O(s2), .SR_CONFIG_O(s3), .REFUSED_O(rf), .FOUR_WIRE_O(fw),
        .PAD_O(pad));
    fsrb_host host (.lclk_i(lclk), .req_valid_o(lv), .req_o(lq));

    // verdict and end of run
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // bounded wait for the busy flag to drop
    task automatic idle();
        int n;
        n = 0;
        while (s1[0] !== 1'b0 && n < 3000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        `C("busy_end", 1'b0, s1[0])
    endtask

    // one link command, then time for the answer to land
    task automatic op(input fsrb_cmd_e c, input logic [1:0] i, input logic [7:0] d,
        input logic [23:0] a);
        if (c == FSRB_CMD_QPI_IN)
            mfw = mfw | mdl[1][1];
        if (c == FSRB_CMD_QPI_OUT)
            mfw = 1'b0;
        host.issue('{c, i, d, a}, $random(seed) & 3);
        repeat (8) @(posedge clk);
        #1;
        `C("mode", mfw, fw)
    endtask

    // latch, register write, completion, then the whole bank against the model
    task automatic wr(input logic [1:0] i, input logic [7:0] d);
        logic lk;
        op(FSRB_CMD_WREN, 2'h0, 8'h00, 24'h0);
        lk = mdl[1][0] || (mdl[0][7] && !mdl[1][1] && !wp_n);
        op(FSRB_CMD_WRSR, i, d, 24'h0);
        idle();
        if (lk)
            mdl[0] = mdl[0] | 32'h2;
        else if (i == FSRB_IDX_FLAGS)
            mdl[0] = int'(d & 8'hfc);
        else if (i == FSRB_IDX_QUAD)
            mdl[1] = int'((d & 8'h41) | ((8'(mdl[1]) | d) & 8'h3c)
                | {6'h00, d[1] | mfw, 1'b0});
        else
            mdl[2] = int'(d & 8'he4);
        `C("model", {8'(mdl[0]), 8'(mdl[1]), 8'(mdl[2])}, {s1, s2, s3})
    endtask

    // scenarios
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `C("flags_rst", 8'h00, s1)
        `C("quad_rst", 8'h00, s2)
        `C("cfg_rst", 8'h40, s3)
        `C("drv_rst", 7'h32, pad.drive_pct)
        $display("reset test done");
        m = $random(seed) & 8'h7c;
        op(FSRB_CMD_WRSR, FSRB_IDX_FLAGS, 8'(m), 24'h0);
        `C("no_wel", 9'h100, {rf, s1})
        op(FSRB_CMD_WREN, 2'h0, 8'h00, 24'h0);
        `C("wel", 1'b1, s1[1])
        op(FSRB_CMD_WRSR, FSRB_IDX_FLAGS, 8'(m), 24'h0);
        `C("busy", 1'b1, s1[0])
        idle();
        `C("flags", 8'(m), s1)
        mdl[0] = m;
        for (k = 0; k < 4; k++)
        begin
            m = ($random(seed) & 8'h1b) | (k << 5) | ((k & 1) << 7);
            wr(FSRB_IDX_CONFIG, 8'(m));
            `C("cfg", 8'(m) & 8'he4, s3)
            `C("drv", 7'(100 - 25 * k), pad.drive_pct)
            `C("drv_code", 2'(k), pad.drive_strength_field)
            `C("pin_rst", k[0], pad.reset_active)
            `C("pin_pause", !k[0], pad.pause_active)
        end
        $display("config test done");
        op(FSRB_CMD_QPI_IN, 2'h0, 8'h00, 24'h0);
        `C("qpi_off", 2'h2, {rf, fw})
        wr(FSRB_IDX_QUAD, 8'h02);
        `C("qe_pins", 3'h4, {pad.quad_io_enable, pad.wp_active, pad.pause_active})
        `C("qe_rst_pin", 1'b0, pad.reset_active)
        op(FSRB_CMD_QPI_IN, 2'h0, 8'h00, 24'h0);
        `C("qpi_on", 1'b1, fw)
        wr(FSRB_IDX_QUAD, 8'h00);
        `C("qe_held", 1'b1, s2[1])
        op(FSRB_CMD_QPI_OUT, 2'h0, 8'h00, 24'h0);
        wr(FSRB_IDX_QUAD, 8'h00);
        `C("qe_clr", 1'b0, s2[1])
        k = $random(seed) & 3;
        wr(FSRB_IDX_QUAD, 8'h04 << k);
        wr(FSRB_IDX_QUAD, 8'h00);
        `C("lock", 4'h1 << k, s2[5:2])
        $display("quad test done");
        wr(FSRB_IDX_FLAGS, 8'h04);
        for (k = 0; k < 4; k++)
        begin
            if (k == 2)
                wr(FSRB_IDX_QUAD, 8'h40);
            op(FSRB_CMD_WREN, 2'h0, 8'h00, 24'h0);
            op(FSRB_CMD_PROG, 2'h0, 8'h00, k[0] ? 24'h000000 : 24'hff0000);
            `C("prot", k[0] == k[1], rf)
            idle();
        end
        wr(FSRB_IDX_QUAD, 8'h00);
        // one bottom sector, then the block-lock scheme over the same address
        wr(FSRB_IDX_FLAGS, 8'h64);
        for (k = 0; k < 4; k++)
        begin
            if (k == 2)
                wr(FSRB_IDX_CONFIG, 8'h04);
            @(posedge clk) blk_hit <= (k == 2);
            op(FSRB_CMD_WREN, 2'h0, 8'h00, 24'h0);
            op(FSRB_CMD_PROG, 2'h0, 8'h00, (k == 1) ? 24'h001000 : 24'h000000);
            `C("sec_prot", !k[0], rf)
            idle();
        end
        wr(FSRB_IDX_CONFIG, 8'h00);
        wr(FSRB_IDX_FLAGS, 8'h00);
        op(FSRB_CMD_WREN, 2'h0, 8'h00, 24'h0);
        op(FSRB_CMD_SERASE, 2'h0, 8'h00, 24'hff0000);
        `C("erase", 2'h1, {rf, s1[0]})
        op(FSRB_CMD_SUSP, 2'h0, 8'h00, 24'h0);
        `C("susp", 2'h2, {s2[7], s1[0]})
        op(FSRB_CMD_RESUME, 2'h0, 8'h00, 24'h0);
        `C("resume", 1'b0, s2[7])
        idle();
        $display("array test done");
        wr(FSRB_IDX_FLAGS, 8'h80);
        @(posedge clk) wp_n <= 1'b0;
        wr(FSRB_IDX_FLAGS, 8'h84);
        `C("hw_prot", 2'h2, {rf, s1[2]})
        @(posedge clk) wp_n <= 1'b1;
        wr(FSRB_IDX_FLAGS, 8'h04);
        `C("hw_free", 8'h04, s1)
        $display("protect test done");
        test_done();
    end

    // cuts a hang short
    initial
    begin
        #5000000;
        err_count++;
        test_done();
    end
endmodule

`default_nettype wire
